// >>> sim/ssr_host_model.sv
// Remote controller model that issues parsed common commands.
`default_nettype none
module ssr_host_model
   import ssr_pkg::*;
(
   input  wire logic       clk,
   output var  logic       cmd_valid,
   output var  ssr_cmd_t   cmd_code,
   output var  logic [7:0] cmd_param
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle state after time zero: no command on the port.
   initial begin
      cmd_valid = 1'b0;
      cmd_code  = SSR_CMD_NONE;
      cmd_param = 8'h5a;
   end

   // One command word per call, held across the taking edge.
   // Afterwards code and parameter are scrambled, so that a design which
   // reads them without the valid strobe sees garbage, not stale values.
   task automatic send(input ssr_cmd_t code, input logic [7:0] param);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code  = code;
      cmd_param = param;
      @(posedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_code  = ssr_cmd_t'(~code);
      cmd_param = ~param;
   endtask
endmodule // ssr_host_model
`default_nettype wire

// >>> sim/ssr_top_tb.sv
// Self-checking bench for the status reporting block.
`default_nettype none
module ssr_top_tb
   import ssr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic       clk, resetn, group_trigger, mode_err_alarm, meas_running;
   logic       cmd_valid, resp_valid_ff, resp_empty_ff, srq_ff;
   logic       meas_start_ff, meas_restart_ff;
   ssr_cmd_t   cmd_code;
   logic [7:0] cmd_param, resp_data_ff, status_byte_ff, ese_ff, sre_ff;
   logic [3:0] evt, lv;
   logic [7:0] m_esr, m_sre, p, e;
   logic [31:0] r;
   logic [7:0] wt [4] = '{8'h01, 8'h08, 8'h10, 8'h20};
   integer     mismatches, samples_checked, seed, i;

   ssr_host_model u_host (.clk(clk), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_param(cmd_param));

   ssr_top u_dut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_param(cmd_param), .evt_opc(evt[0]),
      .evt_dde(evt[1]), .evt_exe(evt[2]), .evt_cme(evt[3]),
      .oper_summary(lv[3]), .ques_summary(lv[1]), .out_queue_busy(lv[2]),
      .err_queue_busy(lv[0]), .group_trigger(group_trigger),
      .mode_err_alarm(mode_err_alarm), .meas_running(meas_running),
      .resp_valid_ff(resp_valid_ff), .resp_data_ff(resp_data_ff),
      .resp_empty_ff(resp_empty_ff), .meas_start_ff(meas_start_ff),
      .meas_restart_ff(meas_restart_ff), .srq_ff(srq_ff),
      .status_byte_ff(status_byte_ff), .ese_ff(ese_ff), .sre_ff(sre_ff));

   // Free-running 10 MHz clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Compares one value and keeps the tallies.
   task automatic chk(input string nm, input logic [7:0] ex,
                      input logic [7:0] got);
      samples_checked++;
      if (got !== ex) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Status byte the model predicts from the present levels and registers.
   function automatic logic [7:0] exp_stb();
      logic [7:0] s;
      s = {lv[3], 1'b0, |m_esr, lv[2], lv[1], lv[0], 2'b00};
      s[6] = |(s & m_sre & 8'hbc);
      return s;
   endfunction

   // Issues a query and checks the one-cycle answer.
   task automatic query(input ssr_cmd_t c, input logic [7:0] ex);
      u_host.send(c, 8'h00);
      chk("resp_valid", 8'h01, {7'h0, resp_valid_ff});
      chk("resp_empty", 8'h00, {7'h0, resp_empty_ff});
      chk("resp_data", ex, resp_data_ff);
      if (c == SSR_CMD_ESR_QRY)
         m_esr = 8'h00;
   endtask

   // One-cycle event pulse on input b.
   task automatic pulse(input int b);
      @(negedge clk);
      evt[b] = 1'b1;
      @(negedge clk);
      evt[b] = 1'b0;
      m_esr = m_esr | wt[b];
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Cuts a hang short; the sequence needs well under 1000 cycles.
   initial begin
      #(100 * 4000);
      mismatches++;
      finish_test();
   end

   // Main sequence; inputs move only on falling edges.
   initial begin
      seed = 32'h7228;
      mismatches = 0;
      samples_checked = 0;
      resetn = 1'b0;
      evt = 4'h0;
      lv = 4'h0;
      group_trigger = 1'b0;
      mode_err_alarm = 1'b0;
      meas_running = 1'b0;
      m_sre = 8'h00;
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      m_esr = 8'h80;
      query(SSR_CMD_ESR_QRY, 8'h80);
      query(SSR_CMD_ESR_QRY, 8'h00);
      for (i = 0; i < 4; i++) begin
         pulse(i);
         query(SSR_CMD_ESR_QRY, wt[i]);
      end
      pulse(3);
      query(SSR_CMD_STB_QRY, 8'h20);
      query(SSR_CMD_ESR_QRY, 8'h20);
      $display("test events done");
      // Enable registers, boundary values first, each read back twice.
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         p = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r[7:0];
         u_host.send(SSR_CMD_ESE_SET, p);
         chk("ese_ff", p, ese_ff);
         query(SSR_CMD_ESE_QRY, p);
         query(SSR_CMD_ESE_QRY, p);
         u_host.send(SSR_CMD_SRE_SET, ~p);
         m_sre = ~p;
         chk("sre_ff", m_sre, sre_ff);
         query(SSR_CMD_SRE_QRY, m_sre);
         query(SSR_CMD_SRE_QRY, m_sre);
      end
      $display("test enables done");
      // Random summaries, events and enables against the status byte.
      for (i = 0; i < 24; i++) begin
         r = $random(seed);
         u_host.send(SSR_CMD_SRE_SET, r[15:8]);
         m_sre = r[15:8];
         @(negedge clk);
         lv = r[3:0];
         if (r[4])
            pulse(r[6:5]);
         e = exp_stb();
         query(SSR_CMD_STB_QRY, e);
         chk("status_byte_ff", e, status_byte_ff);
         chk("srq_ff", {7'h0, e[6]}, {7'h0, srq_ff});
         if (r[7])
            query(SSR_CMD_ESR_QRY, m_esr);
      end
      $display("test status byte done");
      // Trigger by command and by bus trigger, in every mode pairing.
      for (i = 0; i < 8; i++) begin
         @(negedge clk);
         mode_err_alarm = i[1];
         meas_running = i[2];
         if (i[0]) begin
            u_host.send(SSR_CMD_TRG, 8'h00);
         end else begin
            @(negedge clk);
            group_trigger = 1'b1;
            @(negedge clk);
            group_trigger = 1'b0;
         end
         chk("meas_start", {7'h0, i[1]}, {7'h0, meas_start_ff});
         chk("meas_restart", {7'h0, i[1] & i[2]},
             {7'h0, meas_restart_ff});
      end
      $display("test trigger done");
      u_host.send(SSR_CMD_OPT_QRY, 8'h00);
      chk("opt_valid", 8'h01, {7'h0, resp_valid_ff});
      chk("opt_empty", 8'h01, {7'h0, resp_empty_ff});
      chk("opt_data", 8'h00, resp_data_ff);
      $display("test options done");
      finish_test();
   end
endmodule // ssr_top_tb
`default_nettype wire

// >>> src/ssr_event_reg.sv
// Sticky event register with per-bit set-over-clear behaviour.
`default_nettype none
module ssr_event_reg
   import ssr_pkg::*;
#(
   parameter int unsigned WIDTH = SSR_REG_W,
   parameter logic [7:0]  IMPL  = SSR_ESR_IMPL
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] set_bits,
   input  wire logic             clear,
   output var  logic [WIDTH-1:0] q
);

   // The implemented-bit mask is a byte, so the register must be one.
   if (WIDTH != 8) begin : g_width_check
      $error("ssr_event_reg supports only an 8-bit register");
   end

   // One sticky flop per implemented bit; absent bits are held at zero.
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      if (IMPL[i]) begin : g_impl
         logic evt_ff;
         logic nxt_evt_ff;
         // A set in the clearing cycle must survive, so set is ORed last.
         assign nxt_evt_ff = set_bits[i] | (evt_ff & ~clear);
         assign q[i] = evt_ff;
         // Each bit keeps its own flop so that no two processes share q.
         always_ff @(posedge clk) begin
            if (!resetn) begin
               evt_ff <= SSR_ESR_RST[i];
            end else begin
               evt_ff <= nxt_evt_ff;
            end
         end
         property p_set_wins;
            @(posedge clk) disable iff (!resetn)
            set_bits[i] |=> q[i];
         endproperty
         a_set_wins : assert property (p_set_wins)
            else $error("event lost in clearing cycle");
      end else begin : g_absent
         assign q[i] = 1'b0;
      end
   end

endmodule // ssr_event_reg
`default_nettype wire

// >>> src/ssr_pkg.sv
// Shared constants and command codes for the status reporting block.
`default_nettype none
package ssr_pkg;

   // Width of every status and enable register.
   localparam int unsigned SSR_REG_W = 8;

   // Decoded common commands delivered by the command parser.
   typedef enum logic [3:0] {
      SSR_CMD_NONE,
      SSR_CMD_ESE_SET,
      SSR_CMD_ESE_QRY,
      SSR_CMD_ESR_QRY,
      SSR_CMD_SRE_SET,
      SSR_CMD_SRE_QRY,
      SSR_CMD_STB_QRY,
      SSR_CMD_TRG,
      SSR_CMD_OPT_QRY
   } ssr_cmd_t;

   // Standard event register bit positions.
   localparam int unsigned SSR_ESR_OPC_BIT = 0;
   localparam int unsigned SSR_ESR_DDE_BIT = 3;
   localparam int unsigned SSR_ESR_EXE_BIT = 4;
   localparam int unsigned SSR_ESR_CME_BIT = 5;
   localparam int unsigned SSR_ESR_PON_BIT = 7;
   // Bits that exist in the event register; the rest read as zero.
   localparam logic [7:0] SSR_ESR_IMPL = 8'hb9;

   // Status byte and service request enable bit positions.
   localparam int unsigned SSR_STB_QUE_BIT  = 2;
   localparam int unsigned SSR_STB_QUES_BIT = 3;
   localparam int unsigned SSR_STB_MAV_BIT  = 4;
   localparam int unsigned SSR_STB_ESB_BIT  = 5;
   localparam int unsigned SSR_STB_MSS_BIT  = 6;
   localparam int unsigned SSR_STB_OPER_BIT = 7;
   // Summary bits that may raise a service request (bit 6 excluded).
   localparam logic [7:0] SSR_SRQ_MASK = 8'hbc;

   // Values after reset.
   localparam logic [7:0] SSR_ESE_RST = 8'h00;
   localparam logic [7:0] SSR_SRE_RST = 8'h00;
   localparam logic [7:0] SSR_ESR_RST = 8'h00;
   localparam logic [7:0] SSR_STB_RST = 8'h00;

   // Cycles from a taken command to its answer or trigger pulse.
   localparam int unsigned SSR_RESP_LAT = 1;

endpackage
`default_nettype wire

// >>> src/ssr_top.sv
// Common-command status reporting, service request and trigger logic.
`default_nettype none
module ssr_top
   import ssr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       cmd_valid,
   input  wire ssr_cmd_t   cmd_code,
   input  wire logic [7:0] cmd_param,
   input  wire logic       evt_opc,
   input  wire logic       evt_dde,
   input  wire logic       evt_exe,
   input  wire logic       evt_cme,
   input  wire logic       oper_summary,
   input  wire logic       ques_summary,
   input  wire logic       out_queue_busy,
   input  wire logic       err_queue_busy,
   input  wire logic       group_trigger,
   input  wire logic       mode_err_alarm,
   input  wire logic       meas_running,
   output var  logic       resp_valid_ff,
   output var  logic [7:0] resp_data_ff,
   output var  logic       resp_empty_ff,
   output var  logic       meas_start_ff,
   output var  logic       meas_restart_ff,
   output var  logic       srq_ff,
   output var  logic [7:0] status_byte_ff,
   output var  logic [7:0] ese_ff,
   output var  logic [7:0] sre_ff
);

   // Command decode.
   logic       do_ese_set;
   logic       do_ese_qry;
   logic       do_esr_qry;
   logic       do_sre_set;
   logic       do_sre_qry;
   logic       do_stb_qry;
   logic       do_trg;
   logic       do_opt_qry;
   logic       is_query;
   assign do_ese_set = cmd_valid && (cmd_code == SSR_CMD_ESE_SET);
   assign do_ese_qry = cmd_valid && (cmd_code == SSR_CMD_ESE_QRY);
   assign do_esr_qry = cmd_valid && (cmd_code == SSR_CMD_ESR_QRY);
   assign do_sre_set = cmd_valid && (cmd_code == SSR_CMD_SRE_SET);
   assign do_sre_qry = cmd_valid && (cmd_code == SSR_CMD_SRE_QRY);
   assign do_stb_qry = cmd_valid && (cmd_code == SSR_CMD_STB_QRY);
   assign do_trg     = cmd_valid && (cmd_code == SSR_CMD_TRG);
   assign do_opt_qry = cmd_valid && (cmd_code == SSR_CMD_OPT_QRY);
   assign is_query   = do_ese_qry | do_esr_qry | do_sre_qry
                     | do_stb_qry | do_opt_qry;

   // Power-on is latched once after reset release, as a cold start would.
   logic       pon_pending_ff;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pon_pending_ff <= 1'b1;
      end else begin
         pon_pending_ff <= 1'b0;
      end
   end

   // Event inputs gathered at their bit positions.
   logic [7:0] esr_set;
   logic [7:0] esr_q;
   assign esr_set[SSR_ESR_OPC_BIT] = evt_opc;
   assign esr_set[2:1]             = 2'b00;
   assign esr_set[SSR_ESR_DDE_BIT] = evt_dde;
   assign esr_set[SSR_ESR_EXE_BIT] = evt_exe;
   assign esr_set[SSR_ESR_CME_BIT] = evt_cme;
   assign esr_set[6]               = 1'b0;
   assign esr_set[SSR_ESR_PON_BIT] = pon_pending_ff;

   // Reading the event register clears it; new events still win.
   ssr_event_reg #(
      .WIDTH (SSR_REG_W),
      .IMPL  (SSR_ESR_IMPL)
   ) u_esr (
      .clk      (clk),
      .resetn   (resetn),
      .set_bits (esr_set),
      .clear    (do_esr_qry),
      .q        (esr_q)
   );

   // Status byte assembly; bits 1 and 0 are unused and read as zero.
   logic       esb;
   logic       mss;
   logic [7:0] stb_sum;
   logic [7:0] stb_now;
   assign esb = |esr_q;
   assign stb_sum[1:0]             = 2'b00;
   assign stb_sum[SSR_STB_QUE_BIT]  = err_queue_busy;
   assign stb_sum[SSR_STB_QUES_BIT] = ques_summary;
   assign stb_sum[SSR_STB_MAV_BIT]  = out_queue_busy;
   assign stb_sum[SSR_STB_ESB_BIT]  = esb;
   assign stb_sum[SSR_STB_MSS_BIT]  = 1'b0;
   assign stb_sum[SSR_STB_OPER_BIT] = oper_summary;
   // Bit 6 of the enable is masked so the summary cannot feed itself.
   assign mss = |(stb_sum & sre_ff & SSR_SRQ_MASK);
   assign stb_now = stb_sum | ({7'h00, mss} << SSR_STB_MSS_BIT);

   // Answer selection for the query just taken.
   logic [7:0] resp_sel;
   assign resp_sel = do_ese_qry ? ese_ff  :
                     do_esr_qry ? esr_q   :
                     do_sre_qry ? sre_ff  :
                     do_stb_qry ? stb_now :
                     8'h00;

   // Trigger qualification; a running measurement also gets a restart pulse.
   logic       trig_any;
   logic       trig_ok;
   assign trig_any = do_trg | group_trigger;
   assign trig_ok  = trig_any & mode_err_alarm;

   // Enable registers: the parameter is stored exactly as sent.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ese_ff <= SSR_ESE_RST;
         sre_ff <= SSR_SRE_RST;
      end else begin
         if (do_ese_set) begin
            ese_ff <= cmd_param;
         end
         if (do_sre_set) begin
            sre_ff <= cmd_param;
         end
      end
   end

   // Response port; queries never touch the enable registers.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         resp_valid_ff <= 1'b0;
         resp_data_ff  <= 8'h00;
         resp_empty_ff <= 1'b0;
      end else begin
         resp_valid_ff <= is_query;
         resp_data_ff  <= resp_sel;
         resp_empty_ff <= do_opt_qry;
      end
   end

   // Trigger pulses and registered status outputs.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meas_start_ff   <= 1'b0;
         meas_restart_ff <= 1'b0;
         srq_ff          <= 1'b0;
         status_byte_ff  <= SSR_STB_RST;
      end else begin
         meas_start_ff   <= trig_ok;
         meas_restart_ff <= trig_ok & meas_running;
         srq_ff          <= mss;
         status_byte_ff  <= stb_now;
      end
   end

   // Checks on the answers and pulses.
   sequence s_ese_qry;
      do_ese_qry;
   endsequence
   sequence s_answer;
      ##1 resp_valid_ff && !resp_empty_ff;
   endsequence

   property p_ese_qry;
      logic [7:0] v;
      @(posedge clk) disable iff (!resetn)
      (s_ese_qry, v = ese_ff) |-> s_answer ##0 (resp_data_ff == v);
   endproperty
   a_ese_qry : assert property (p_ese_qry)
      else $error("enable query answered a wrong value");

   property p_esr_qry;
      logic [7:0] v;
      @(posedge clk) disable iff (!resetn)
      (do_esr_qry, v = esr_q) |-> s_answer ##0 (resp_data_ff == v);
   endproperty
   a_esr_qry : assert property (p_esr_qry)
      else $error("event query answered a wrong value");

   property p_esr_cme_only;
      @(posedge clk) disable iff (!resetn)
      (do_esr_qry && esr_q == 8'h20) |=> (resp_data_ff == 8'h20);
   endproperty
   a_esr_cme_only : assert property (p_esr_cme_only)
      else $error("lone command error did not read as 32");

   property p_sre_load;
      logic [7:0] v;
      @(posedge clk) disable iff (!resetn)
      (do_sre_set, v = cmd_param) |=> (sre_ff == v);
   endproperty
   a_sre_load : assert property (p_sre_load)
      else $error("service enable not loaded");

   property p_sre_qry;
      @(posedge clk) disable iff (!resetn)
      do_sre_qry && !do_sre_set |=> resp_valid_ff
         && resp_data_ff == $past(sre_ff);
   endproperty
   a_sre_qry : assert property (p_sre_qry)
      else $error("service enable query answered a wrong value");

   property p_stb_bits;
      @(posedge clk) disable iff (!resetn)
      do_stb_qry |=> resp_data_ff[SSR_STB_OPER_BIT] == $past(oper_summary)
         && resp_data_ff[SSR_STB_MAV_BIT] == $past(out_queue_busy)
         && resp_data_ff[SSR_STB_QUES_BIT] == $past(ques_summary)
         && resp_data_ff[SSR_STB_QUE_BIT] == $past(err_queue_busy)
         && resp_data_ff[SSR_STB_ESB_BIT] == $past(|esr_q)
         && resp_data_ff[1:0] == 2'b00;
   endproperty
   a_stb_bits : assert property (p_stb_bits)
      else $error("status byte bit placement wrong");

   property p_stb_mss;
      @(posedge clk) disable iff (!resetn)
      do_stb_qry |=> resp_data_ff[SSR_STB_MSS_BIT] == $past(|(sre_ff
         & {oper_summary, 1'b0, |esr_q, out_queue_busy, ques_summary,
            err_queue_busy, 2'b00}));
   endproperty
   a_stb_mss : assert property (p_stb_mss)
      else $error("master summary bit wrong in status byte");

   property p_stb_esb_only;
      @(posedge clk) disable iff (!resetn)
      (do_stb_qry && esb && !oper_summary && !ques_summary
         && !out_queue_busy && !err_queue_busy && !sre_ff[SSR_STB_ESB_BIT])
         |=> (resp_data_ff == 8'h20);
   endproperty
   a_stb_esb_only : assert property (p_stb_esb_only)
      else $error("status byte with only event summary not 32");

   property p_trg_start;
      @(posedge clk) disable iff (!resetn)
      (do_trg && mode_err_alarm) |=> meas_start_ff
         && (meas_restart_ff == $past(meas_running));
   endproperty
   a_trg_start : assert property (p_trg_start)
      else $error("trigger did not start measurement");

   property p_trg_mode;
      @(posedge clk) disable iff (!resetn)
      meas_start_ff |-> $past(mode_err_alarm) && $past(trig_any);
   endproperty
   a_trg_mode : assert property (p_trg_mode)
      else $error("measurement started outside error and alarm mode");

   property p_opt_null;
      @(posedge clk) disable iff (!resetn)
      do_opt_qry |=> resp_valid_ff && resp_empty_ff && resp_data_ff == 8'h00;
   endproperty
   a_opt_null : assert property (p_opt_null)
      else $error("options query did not answer empty");

   property p_cme_sets;
      @(posedge clk) disable iff (!resetn)
      evt_cme |=> esr_q[SSR_ESR_CME_BIT];
   endproperty
   a_cme_sets : assert property (p_cme_sets)
      else $error("command error not recorded at bit 5");

   property p_esb_follows;
      @(posedge clk) disable iff (!resetn)
      ##1 status_byte_ff[SSR_STB_ESB_BIT] == $past(|esr_q);
   endproperty
   a_esb_follows : assert property (p_esb_follows)
      else $error("event summary bit does not follow event register");

   property p_srq_cause;
      @(posedge clk) disable iff (!resetn)
      srq_ff |-> $past(|(stb_sum & sre_ff & SSR_SRQ_MASK));
   endproperty
   a_srq_cause : assert property (p_srq_cause)
      else $error("service request raised without enabled summary");

   property p_qry_keeps;
      @(posedge clk) disable iff (!resetn)
      (is_query && !do_ese_set && !do_sre_set) |=> $stable(ese_ff)
         && $stable(sre_ff);
   endproperty
   a_qry_keeps : assert property (p_qry_keeps)
      else $error("query changed an enable register");

endmodule // ssr_top
`default_nettype wire
